// ### hw/temp_iface_pkg.sv
// constants shared by the two-wire slave interface of the temperature monitor
package temp_iface_pkg;

    // slave addressing: base address, the variant picks the low bit
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h4C;
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
    localparam logic [7:0] GEN_CALL_RESET = 8'h06;
    localparam logic [7:0] ALARM_QUERY_BYTE = 8'h19;
    localparam logic [4:0] HS_CODE_PREFIX = 5'h01;

    // bit counter landmarks inside one nine-bit byte slot
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;

    // reset values
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // bus timeout, held-low time converted to clock cycles
    localparam int unsigned CLK_FREQ_KHZ = 125000;
    localparam int unsigned TIMEOUT_MS = 32;
    localparam int unsigned TIMEOUT_CYCLES_DFLT = TIMEOUT_MS * CLK_FREQ_KHZ;

    // what the byte currently on the bus means to us
    typedef enum logic [2:0] {
        ph_idle,
        ph_addr,
        ph_ptr,
        ph_wdata,
        ph_gc,
        ph_rd,
        ph_alarm,
        ph_skip
    } phase_t;

endpackage : temp_iface_pkg

// ### hw/line_sync.sv
// two-flop synchroniser for levels entering from outside the clock domain
module line_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : line_sync

// ### hw/smbus_slave_pointer_alert_iface.sv
// two-wire slave with pointer register, general call reset, hs switch and alarm response
//
// Behaviour
// - address byte is seven address bits then direction, low write, high read
// - answer only the fixed slave address chosen by variant
// - first written byte loads pointer, later bytes write selected register
// - reads use last written pointer; pointer kept until next write
// - write with only pointer byte updates pointer, writes nothing
// - multi-byte content goes out most significant byte first
// - two-byte read supported; master not-acknowledges second byte
// - either line low 32 ms inside frame resets interface, releases lines
// - code 00001xxx first after start: no ack, switch to hs filters
// - hs operation up to 2.5 MHz until stop, then fast mode
// - acknowledge general call 00h; second byte 06h triggers soft reset
// - soft reset restores power-on values, aborts conversion, releases alarms
// - other general call second bytes: acknowledge only
// - alarm active and query byte read: acknowledge and send own address
// - returned address low bit: one for high limit, zero for low limit
// - after returned address, set alarm mask bit and release alarm output
// - lost arbitration keeps alarm active; release only on a win
// - supply invalid: skip conversions, keep last valid result
// - acknowledge by holding data low during ninth clock pulse
// - mask bit set holds alarm output inactive
module smbus_slave_pointer_alert_iface
    import temp_iface_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DFLT,
    parameter bit ADDR_VARIANT = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic alert_out,
    output logic alert_oe,
    input wire logic alert_cond,
    input wire logic alert_high,
    input wire logic cfg_mask,
    output logic mask_set,
    output logic [7:0] reg_ptr,
    output logic reg_wr_stb,
    output logic [7:0] reg_wr_data,
    input wire logic [15:0] reg_rd_data,
    output logic soft_reset,
    output logic hs_mode,
    input wire logic supply_ok,
    output logic conv_enable,
    input wire logic result_stb,
    input wire logic [11:0] result_in,
    output logic [11:0] result_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin sampling and bus conditions

    logic [2:0] pins_sync;
    wire scl;
    wire sda;
    wire supply_valid;

    line_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h7)
    ) u_pin_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({supply_ok, sda_in, scl_in}),
        .sync_out(pins_sync)
    );

    assign scl = pins_sync[0];
    assign sda = pins_sync[1];
    assign supply_valid = pins_sync[2];

    logic scl_q;
    logic sda_q;

    // previous synchronised levels for edge finding
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // start/stop are data edges while the clock stays high
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_det = scl & scl_q & sda_q & ~sda;
    wire stop_det = scl & scl_q & ~sda_q & sda;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    phase_t phase;
    phase_t next_phase;
    phase_t pend_phase;
    logic [3:0] bit_cnt;
    logic [6:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] rd_lo;
    logic rd_second;
    logic ack_en;
    logic lost;
    logic drive_low;
    logic in_frame;
    logic [31:0] low_cnt;
    logic timeout_hit;

    wire [6:0] own_addr = {SLAVE_ADDR_BASE[6:1], ADDR_VARIANT};
    wire [7:0] rx_byte = {rx_shift, sda};
    wire is_tx = (phase == ph_rd) || (phase == ph_alarm);
    // alarm pin asserted only while unmasked and not being reset
    wire alarm_active = alert_cond & ~cfg_mask & ~soft_reset;

    ////////////////////////////////////////////////////////////////////////////////
    // decode of a completed received byte, used on the eighth rising clock
    logic next_ack;
    logic is_hs_code;
    logic is_own;
    assign is_hs_code = (rx_byte[7:3] == HS_CODE_PREFIX);
    assign is_own = (rx_byte[7:1] == own_addr);

    always_comb begin
        next_ack = 1'b0;
        next_phase = ph_skip;
        unique case (phase)
            ph_addr: begin
                if (is_own) begin
                    next_ack = 1'b1;
                    next_phase = rx_byte[0] ? ph_rd : ph_ptr;
                end else if (rx_byte == GEN_CALL_ADDR) begin
                    next_ack = 1'b1;
                    next_phase = ph_gc;
                end else if (rx_byte == ALARM_QUERY_BYTE && alarm_active) begin
                    next_ack = 1'b1;
                    next_phase = ph_alarm;
                end else begin
                    next_ack = 1'b0; // hs code and foreign addresses are not acked
                    next_phase = ph_skip;
                end
            end
            ph_ptr, ph_wdata: begin
                next_ack = 1'b1;
                next_phase = ph_wdata;
            end
            ph_gc: begin
                next_ack = 1'b1;
                next_phase = ph_skip;
            end
            default: begin
                next_ack = 1'b0;
                next_phase = ph_skip;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timeout: either line held low inside a frame
    always_ff @(posedge clk) begin
        if (!reset_n || !in_frame || (scl && sda)) begin
            low_cnt <= 32'h0000_0000;
        end else if (!timeout_hit) begin
            low_cnt <= low_cnt + 32'h0000_0001;
        end
    end

    assign timeout_hit = in_frame && (low_cnt >= TIMEOUT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // byte engine: sample on rising scl, change the data line on falling scl
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase <= ph_idle;
            pend_phase <= ph_idle;
            bit_cnt <= 4'h0;
            rx_shift <= 7'h00;
            tx_shift <= 8'hFF;
            rd_lo <= 8'hFF;
            rd_second <= 1'b0;
            ack_en <= 1'b0;
            lost <= 1'b0;
            drive_low <= 1'b0;
            in_frame <= 1'b0;
            hs_mode <= 1'b0;
            reg_ptr <= PTR_RESET;
            reg_wr_stb <= 1'b0;
            reg_wr_data <= 8'h00;
            soft_reset <= 1'b0;
            mask_set <= 1'b0;
        end else begin
            reg_wr_stb <= 1'b0;
            soft_reset <= 1'b0;
            mask_set <= 1'b0;
            if (timeout_hit || stop_det) begin
                // release everything and wait for a fresh start
                phase <= ph_idle;
                drive_low <= 1'b0;
                ack_en <= 1'b0;
                in_frame <= 1'b0;
                if (stop_det) begin
                    hs_mode <= 1'b0; // back to fast mode filters
                end
            end else if (start_det) begin
                // also a repeated start: pointer survives it
                phase <= ph_addr;
                bit_cnt <= 4'h0;
                ack_en <= 1'b0;
                drive_low <= 1'b0;
                in_frame <= 1'b1;
            end else if (scl_rise && phase != ph_idle && phase != ph_skip) begin
                if (bit_cnt < BIT_ACK_SLOT) begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (is_tx) begin
                        // a released one read back as zero means another sender won
                        if (phase == ph_alarm && tx_shift[7] && !sda) begin
                            lost <= 1'b1;
                        end
                        tx_shift <= {tx_shift[6:0], 1'b1};
                    end else begin
                        rx_shift <= rx_byte[6:0];
                    end
                    if (bit_cnt == BIT_LAST_DATA && !is_tx) begin
                        ack_en <= next_ack;
                        pend_phase <= next_phase;
                        if (phase == ph_addr && is_hs_code) begin
                            hs_mode <= 1'b1;
                        end
                        if (phase == ph_ptr) begin
                            reg_ptr <= rx_byte; // pointer-only write stops here
                        end
                        if (phase == ph_wdata) begin
                            reg_wr_stb <= 1'b1;
                            reg_wr_data <= rx_byte;
                        end
                        if (phase == ph_gc && rx_byte == GEN_CALL_RESET) begin
                            soft_reset <= 1'b1;
                            reg_ptr <= PTR_RESET;
                        end
                    end
                end else begin
                    // ninth rising clock closes the byte slot
                    bit_cnt <= 4'h0;
                    ack_en <= 1'b0;
                    if (!is_tx) begin
                        phase <= pend_phase;
                        rd_second <= 1'b0;
                        lost <= 1'b0;
                        if (pend_phase == ph_rd) begin
                            tx_shift <= reg_rd_data[15:8]; // msb first
                            rd_lo <= reg_rd_data[7:0];
                        end else if (pend_phase == ph_alarm) begin
                            tx_shift <= {own_addr, alert_high};
                        end
                    end else if (phase == ph_alarm) begin
                        // query complete: only the winner masks its alarm
                        mask_set <= ~lost;
                        phase <= ph_skip;
                    end else if (sda || rd_second) begin
                        phase <= ph_skip; // nack ends the read
                    end else begin
                        tx_shift <= rd_lo; // second byte of a two-byte read
                        rd_second <= 1'b1;
                    end
                end
            end else if (scl_fall) begin
                if (is_tx && bit_cnt < BIT_ACK_SLOT) begin
                    drive_low <= ~tx_shift[7] & ~lost;
                end else begin
                    drive_low <= (bit_cnt == BIT_ACK_SLOT) && ack_en && !is_tx;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain pins: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = drive_low;
    assign alert_out = 1'b0;
    assign alert_oe = alarm_active;

    ////////////////////////////////////////////////////////////////////////////////
    // conversions pause without a good supply; last good result is kept
    assign conv_enable = supply_valid & ~soft_reset;

    always_ff @(posedge clk) begin
        if (!reset_n || soft_reset) begin
            result_out <= RESULT_RESET;
        end else if (result_stb && supply_valid) begin
            result_out <= result_in;
        end
    end

endmodule : smbus_slave_pointer_alert_iface

// ### bench/smbus_slave_pointer_alert_iface_sva.sv
// port-level assertions for the two-wire slave interface
module smbus_slave_pointer_alert_iface_sva
    import temp_iface_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic alert_oe,
    input wire logic alert_cond,
    input wire logic cfg_mask,
    input wire logic mask_set,
    input wire logic [7:0] reg_ptr,
    input wire logic soft_reset,
    input wire logic hs_mode,
    input wire logic conv_enable,
    input wire logic result_stb,
    input wire logic [11:0] result_in,
    input wire logic [11:0] result_out
);
    int unsigned low_cnt;

    // raw pin low time; margin of six covers the two-flop input lag
    always_ff @(posedge clk) begin
        if (!reset_n || scl_in) begin
            low_cnt <= 0;
        end else if (low_cnt < TIMEOUT_CYCLES + 8) begin
            low_cnt <= low_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_bus_timeout: assert property (
        low_cnt == TIMEOUT_CYCLES + 6 |-> !sda_oe) else $error("line still held after timeout");
    a_hs_noack: assert property (
        $rose(hs_mode) |-> ##20 !sda_oe ##8 !sda_oe) else $error("hs code acknowledged");
    a_hs_stop: assert property (
        $fell(hs_mode) |-> scl_in && sda_in) else $error("hs mode left without stop");
    a_soft_pulse: assert property (
        soft_reset |=> !soft_reset) else $error("soft reset longer than one cycle");
    a_soft_ptr: assert property (
        soft_reset |-> ##[0:2] reg_ptr == PTR_RESET) else $error("pointer kept over soft reset");
    a_conv_abort: assert property (
        soft_reset |-> !conv_enable) else $error("conversion not aborted");
    a_alarm_gate: assert property (
        alert_oe == (alert_cond && !cfg_mask && !soft_reset)) else $error("alarm pin level wrong");
    a_mask_release: assert property (
        mask_set |-> !sda_oe) else $error("mask set while driving data");
    a_result_load: assert property (
        result_stb && conv_enable |=> result_out == $past(result_in)) else $error("result not taken");
    a_supply_hold: assert property (
        result_stb && !conv_enable && !soft_reset |=> $stable(result_out))
        else $error("result changed with bad supply");
    a_result_cause: assert property (
        $changed(result_out) |-> $past(result_stb) || $past(soft_reset) || soft_reset)
        else $error("result changed without cause");
endmodule : smbus_slave_pointer_alert_iface_sva

// ### bench/smbus_master_model.sv
// behavioural bus master; scl rests high between frames, sda has a pull-up
module smbus_master_model (
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one bit: data set while scl low, read back in mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #40 scl = 1'b1;
        #40 r = sda_wire;
        #40 scl = 1'b0;
        #40;
    endtask : bit_io

    // works as first or repeated start
    task automatic start_cond();
        sda_pull = 1'b0;
        #40 scl = 1'b1;
        #40 sda_pull = 1'b1;
        #40 scl = 1'b0;
        #40;
    endtask : start_cond

    task automatic stop_cond();
        sda_pull = 1'b1;
        #40 scl = 1'b1;
        #40 sda_pull = 1'b0;
        #80;
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send_byte

    // pull marks bits that a rival responder forces low
    task automatic recv_byte(input logic [7:0] pull, input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(~pull[i], d[i]);
        end
        bit_io(~ack, r);
    endtask : recv_byte
endmodule : smbus_master_model

// ### bench/test_smbus_slave_pointer_alert_iface.sv
// self-checking bench for the two-wire slave interface
module test_smbus_slave_pointer_alert_iface import temp_iface_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TOUT = 2000;
    localparam logic [7:0] AW = {SLAVE_ADDR_BASE, 1'b0};
    localparam logic [7:0] AR = {SLAVE_ADDR_BASE, 1'b1};
    logic clk, reset_n, scl, sda_pull, sda_wire, sda_out, sda_oe, alert_out, alert_oe;
    logic alert_cond, alert_high, cfg_mask, mask_set, reg_wr_stb, soft_reset, hs_mode;
    logic supply_ok, conv_enable, result_stb, a;
    logic [7:0] reg_ptr, reg_wr_data, wr_last, hi, lo;
    logic [11:0] result_in, result_out;
    logic [15:0] reg_rd_data;
    int err_total, compares, wr_cnt, sr_cnt, ms_cnt, n0;

    // open-drain wire with pull-up; register file stand-in
    assign sda_wire = ~(sda_oe | sda_pull);
    assign reg_rd_data = {reg_ptr, ~reg_ptr};

    // host side: count strobes, keep the mask bit as the register file would
    always @(posedge clk) begin
        if (reg_wr_stb) begin
            wr_cnt <= wr_cnt + 1;
            wr_last <= reg_wr_data;
        end
        if (soft_reset) sr_cnt <= sr_cnt + 1;
        if (mask_set) ms_cnt <= ms_cnt + 1;
        if (mask_set) cfg_mask <= 1'b1;
        else if (soft_reset) cfg_mask <= 1'b0;
    end

    smbus_master_model m (.sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
    smbus_slave_pointer_alert_iface #(.TIMEOUT_CYCLES(TOUT)) dut (
        .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .alert_cond(alert_cond),
        .alert_high(alert_high), .cfg_mask(cfg_mask), .mask_set(mask_set), .reg_ptr(reg_ptr),
        .reg_wr_stb(reg_wr_stb), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .soft_reset(soft_reset), .hs_mode(hs_mode), .supply_ok(supply_ok),
        .conv_enable(conv_enable), .result_stb(result_stb), .result_in(result_in),
        .result_out(result_out));

    ////////////////////////////////////////////////////////////////////////////
    // wide enough for the packed multi-field compares below, so no field is cut off
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic report_and_stop();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // write transfer with pointer first; optional data byte
    task automatic wr(input logic [7:0] p, input bit two, input logic [7:0] d);
        m.start_cond();
        m.send_byte(AW, a);
        check(a, 1);
        m.send_byte(p, a);
        check(reg_ptr, p);
        if (two) m.send_byte(d, a);
        m.stop_cond();
    endtask : wr

    task automatic t_write();
        n0 = wr_cnt;
        wr(8'h05, 1, 8'hA5);
        check(16'(wr_cnt - n0), 1);
        check(wr_last, 8'hA5);
        n0 = wr_cnt;
        wr(8'h3C, 0, 8'h00);
        check(16'(wr_cnt - n0), 0);
    endtask : t_write

    task automatic t_read();
        m.start_cond();
        m.send_byte(AR, a);
        m.recv_byte(8'h00, 1, hi);
        m.recv_byte(8'h00, 0, lo);
        m.stop_cond();
        check({hi, lo}, 16'h3CC3);
        for (int k = 0; k < 2; k++) begin
            m.start_cond();
            if (k == 0) m.send_byte(AW, a);
            if (k == 0) m.send_byte(8'h21, a);
            if (k == 0) m.start_cond();
            m.send_byte(AR, a);
            m.recv_byte(8'h00, 0, hi);
            m.stop_cond();
            check(hi, 8'h21);
        end
    endtask : t_read

    task automatic t_refuse();
        m.start_cond();
        m.send_byte({SLAVE_ADDR_BASE ^ 7'h01, 1'b0}, a);
        check(a, 0);
        m.send_byte(8'h77, a);
        m.stop_cond();
        check({a, reg_ptr}, 9'h021);
        for (int i = 0; i < 8; i++) begin
            m.start_cond();
            m.send_byte({HS_CODE_PREFIX, 3'(i)}, a);
            check({a, hs_mode}, 2'b01);
            // the master code is refused, so the address follows a repeated start
            m.start_cond();
            m.send_byte(AW, a);
            check(a, 1);
            m.stop_cond();
            check(hs_mode, 0);
        end
    endtask : t_refuse

    task automatic t_gencall();
        n0 = sr_cnt;
        m.start_cond();
        m.send_byte(GEN_CALL_ADDR, a);
        check(a, 1);
        m.send_byte(8'h12, a);
        m.stop_cond();
        check({a, reg_ptr, 8'(sr_cnt - n0)}, 17'h1_2100);
        m.start_cond();
        m.send_byte(GEN_CALL_ADDR, a);
        m.send_byte(GEN_CALL_RESET, a);
        m.stop_cond();
        check({reg_ptr, 8'(sr_cnt - n0)}, 16'h0001);
    endtask : t_gencall

    task automatic t_alarm();
        alert_cond = 1'b1;
        for (int h = 0; h < 3; h++) begin
            alert_high = h[0];
            cyc(3);
            check(alert_oe, 1);
            n0 = ms_cnt;
            m.start_cond();
            m.send_byte(ALARM_QUERY_BYTE, a);
            check(a, 1);
            m.recv_byte((h == 2) ? 8'h80 : 8'h00, 0, hi);
            m.stop_cond();
            if (h == 2) check({hi, 8'(ms_cnt - n0), 7'(alert_oe)}, {8'h7F, 8'h00, 7'h01});
            if (h == 2) break;
            check(hi, {SLAVE_ADDR_BASE, h[0]});
            check({8'(ms_cnt - n0), cfg_mask, alert_oe}, 10'h006);
            cfg_mask = 1'b0;
            cyc(2);
            check(alert_oe, 1);
        end
        alert_cond = 1'b0;
        cyc(3);
        m.start_cond();
        m.send_byte(ALARM_QUERY_BYTE, a);
        m.stop_cond();
        check(a, 0);
    endtask : t_alarm

    task automatic t_supply();
        for (int s = 1; s >= 0; s--) begin
            supply_ok = s[0];
            cyc(4);
            check(conv_enable, s[0]);
            result_in = s[0] ? 12'h456 : 12'h123;
            result_stb = 1'b1;
            cyc(1);
            result_stb = 1'b0;
            cyc(2);
            check(result_out, 12'h456);
        end
        supply_ok = 1'b1;
    endtask : t_supply

    task automatic t_timeout();
        m.start_cond();
        for (int i = 7; i >= 0; i--) m.bit_io(AW[i], a);
        cyc(10);
        check(sda_oe, 1);
        check({sda_out, alert_out}, 2'b00);
        cyc(TOUT + 10);
        check(sda_oe, 0);
        m.stop_cond();
        wr(8'h07, 0, 8'h00);
    endtask : t_timeout

    ////////////////////////////////////////////////////////////////////////////
    // clock, guard against a hang, then the main sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        {reset_n, alert_cond, alert_high, cfg_mask, result_stb} = '0;
        {err_total, compares, wr_cnt, sr_cnt, ms_cnt} = '0;
        supply_ok = 1'b1;
        result_in = 12'h000;
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        cyc(5);
        t_write();
        t_read();
        t_refuse();
        t_gencall();
        t_alarm();
        t_supply();
        t_timeout();
        report_and_stop();
    end
endmodule : test_smbus_slave_pointer_alert_iface

bind smbus_slave_pointer_alert_iface smbus_slave_pointer_alert_iface_sva #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
    .alert_oe(alert_oe), .alert_cond(alert_cond), .cfg_mask(cfg_mask), .mask_set(mask_set),
    .reg_ptr(reg_ptr), .soft_reset(soft_reset), .hs_mode(hs_mode), .conv_enable(conv_enable),
    .result_stb(result_stb), .result_in(result_in), .result_out(result_out));
